// ===== hw/hbf_bus_state_filters.sv
// Bus state filters: APB register file and line state qualification controller.
//
// What this block does
// - Bus reset accepted after reset filter time.
// - Host resume accepted after resume filter time.
// - Idle after wake for idle time resuspends.
// - All filters count 60 MHz clock periods.
// - Idle value split across three byte registers.
// - Resume filter bytes, reset 0xB4 and zero.
// - Idle bytes reset to 0x60, 0xEA, zero.
// - Reset filter high byte, reset zero.
// - Reset filter low byte, reset 0xB4.
`timescale 1ns/10ps
module hbf_bus_state_filters
   import hbf_pkg::*;
(
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [DATA_W-1:0] pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [DATA_W-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   // PHY receiver, asynchronous
   input  wire logic [1:0]        lineState,
   input  wire logic              wakeStable,
   // Link controller requests
   input  wire logic              devResumeReq,
   input  wire logic              suspendReq,
   // Qualified bus events
   output logic                   busResetActive,
   output logic                   hostResumeSeen,
   output logic                   idleResuspend,
   output logic      [2:0]        linkState
);

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.

   logic [2:0] syncOut;
   hbf_line_t  line;
   logic       wakeSync;
   logic       wakePrev_r;
   wire        wakeRise = wakeSync && !wakePrev_r;

   hbf_sync2 #(.W(3)) u_sync
   (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .asyncIn ({wakeStable, lineState}),
      .syncOut (syncOut)
   );

   assign line     = hbf_line_t'(syncOut[1:0]);
   assign wakeSync = syncOut[2];

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         wakePrev_r <= 1'b0;
      else
         wakePrev_r <= wakeSync;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode.

   logic                  setupPhase;
   logic                  accessPhase;
   logic [IDX_W-1:0]      regIdx;
   logic                  aligned;
   logic                  hitRstLow;
   logic                  hitRstHigh;
   logic                  hitResLow;
   logic                  hitResHigh;
   logic                  hitIdleLow;
   logic                  hitIdleMid;
   logic                  hitIdleTop;
   logic                  hitStatus;
   logic                  mapped;
   logic                  wrEn;

   assign setupPhase  = psel && !penable;
   assign accessPhase = psel && penable;
   assign regIdx      = paddr[ADDR_W-1:2];
   assign aligned     = paddr[1:0] == 2'b00;
   assign hitRstLow   = aligned && paddr == hbf_reg_addr(IDX_RESET_FILT_LOW);
   assign hitRstHigh  = aligned && paddr == hbf_reg_addr(IDX_RESET_FILT_HIGH);
   assign hitResLow   = aligned && paddr == hbf_reg_addr(IDX_RESUME_LOW);
   assign hitResHigh  = aligned && paddr == hbf_reg_addr(IDX_RESUME_HIGH);
   assign hitIdleLow  = aligned && paddr == hbf_reg_addr(IDX_IDLE_LOW);
   assign hitIdleMid  = aligned && paddr == hbf_reg_addr(IDX_IDLE_MID);
   assign hitIdleTop  = aligned && paddr == hbf_reg_addr(IDX_IDLE_TOP);
   assign hitStatus   = aligned && regIdx == IDX_STATUS;
   assign mapped      = hitRstLow || hitRstHigh || hitResLow || hitResHigh ||
                        hitIdleLow || hitIdleMid || hitIdleTop || hitStatus;

   // Zero wait states: every access phase completes in its first cycle.
   assign pready  = accessPhase;
   assign pslverr = accessPhase && !mapped;
   // Only byte lane 0 carries data; a write without it is accepted and ignored.
   assign wrEn    = accessPhase && pwrite && mapped && pstrb[0];

   ////////////////////////////////////////////////////////////////////////////////
   // Filter value registers.

   logic [7:0]            rstLow_r;
   logic [7:0]            rstHigh_r;
   logic [7:0]            resLow_r;
   logic [7:0]            resHigh_r;
   logic [7:0]            idleLow_r;
   logic [7:0]            idleMid_r;
   logic [IDLE_TOP_W-1:0] idleTop_r;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rstLow_r  <= RST_RESET_FILT_LOW;
         rstHigh_r <= RST_RESET_FILT_HIGH;
         resLow_r  <= RST_RESUME_LOW;
         resHigh_r <= RST_RESUME_HIGH;
         idleLow_r <= RST_IDLE_LOW;
         idleMid_r <= RST_IDLE_MID;
         idleTop_r <= RST_IDLE_TOP;
      end
      else if (wrEn)
      begin
         if (hitRstLow)
            rstLow_r <= pwdata[7:0];
         if (hitRstHigh)
            rstHigh_r <= pwdata[7:0];
         if (hitResLow)
            resLow_r <= pwdata[7:0];
         if (hitResHigh)
            resHigh_r <= pwdata[7:0];
         if (hitIdleLow)
            idleLow_r <= pwdata[7:0];
         if (hitIdleMid)
            idleMid_r <= pwdata[7:0];
         if (hitIdleTop)
            idleTop_r <= pwdata[IDLE_TOP_LSB +: IDLE_TOP_W];
      end
   end

   // Assembled filter times in PHY clock periods.
   logic [SHORT_W-1:0] resetTime;
   logic [SHORT_W-1:0] resumeTime;
   logic [QUAL_W-1:0]  idleTime;

   assign resetTime  = {rstHigh_r, rstLow_r};
   assign resumeTime = {resHigh_r, resLow_r};
   assign idleTime   = {idleTop_r, idleMid_r, idleLow_r};

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, captured in the setup phase.

   hbf_state_t       state_r;
   logic [7:0]       statusByte;
   logic [7:0]       rdByte;
   logic [DATA_W-1:0] prdata_r;

   assign statusByte = {2'b00, syncOut[1:0], busResetActive, state_r};
   assign rdByte     = hitRstLow  ? rstLow_r  :
                       hitRstHigh ? rstHigh_r :
                       hitResLow  ? resLow_r  :
                       hitResHigh ? resHigh_r :
                       hitIdleLow ? idleLow_r :
                       hitIdleMid ? idleMid_r :
                       hitIdleTop ? {idleTop_r, 4'h0} :
                       hitStatus  ? statusByte : 8'h00;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         prdata_r <= '0;
      else if (setupPhase && !pwrite)
         prdata_r <= {24'h00_0000, rdByte};
   end

   assign prdata = prdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Line state qualification controller.

   hbf_timer_if #(.QUAL_W(QUAL_W)) tmr ();

   hbf_qual_timer #(.TW(QUAL_W), .TICKS(TICKS_PER_CYCLE)) u_timer
   (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .tmr     (tmr.timer)
   );

   hbf_state_t state_nxt;
   logic       rstFromWake_r;
   logic       rstFromWake_nxt;
   logic       resumeHit;
   logic       resuspHit;

   always_comb
   begin
      state_nxt       = state_r;
      rstFromWake_nxt = rstFromWake_r;
      resumeHit       = 1'b0;
      resuspHit       = 1'b0;
      unique case (state_r)
         ST_SLEEP:
         begin
            // A resume that the device starts skips the host resume filter.
            if (devResumeReq)
               state_nxt = ST_AWAKE;
            else if (wakeRise)
               state_nxt = ST_WAKE_CHK;
         end
         ST_WAKE_CHK:
         begin
            if (line == LS_RESET)
            begin
               state_nxt       = ST_RST_QUAL;
               rstFromWake_nxt = 1'b1;
            end
            else if (line == LS_RESUME)
               state_nxt = ST_RES_QUAL;
            else if (line == LS_IDLE && tmr.done)
            begin
               state_nxt = ST_SLEEP;
               resuspHit = 1'b1;
            end
         end
         ST_RES_QUAL:
         begin
            if (line != LS_RESUME)
               state_nxt = ST_WAKE_CHK;
            else if (tmr.done)
            begin
               state_nxt = ST_AWAKE;
               resumeHit = 1'b1;
            end
         end
         ST_AWAKE:
         begin
            if (suspendReq)
               state_nxt = ST_SLEEP;
            else if (line == LS_RESET)
            begin
               state_nxt       = ST_RST_QUAL;
               rstFromWake_nxt = 1'b0;
            end
         end
         ST_RST_QUAL:
         begin
            if (line != LS_RESET)
               state_nxt = rstFromWake_r ? ST_WAKE_CHK : ST_AWAKE;
            else if (tmr.done)
               state_nxt = ST_IN_RESET;
         end
         ST_IN_RESET:
         begin
            // The filter guards entry only; leaving reset is taken at once.
            if (line != LS_RESET)
               state_nxt = ST_AWAKE;
         end
         default:
            state_nxt = ST_AWAKE;
      endcase
   end

   // The timer runs only while the watched line holds. It never looks at state_nxt, which hangs on the
   // timer's own done flag. Every way into a qualifying state passes a cycle with the timer stopped,
   // so each qualification starts from zero.
   assign tmr.run   = (state_r == ST_RST_QUAL && line == LS_RESET) ||
                      (state_r == ST_RES_QUAL && line == LS_RESUME) ||
                      (state_r == ST_WAKE_CHK && line == LS_IDLE);
   assign tmr.limit = (state_r == ST_RST_QUAL) ? {4'h0, resetTime}  :
                      (state_r == ST_RES_QUAL) ? {4'h0, resumeTime} :
                      idleTime;

   logic busResetActive_r;
   logic hostResumeSeen_r;
   logic idleResuspend_r;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_r          <= ST_AWAKE;
         rstFromWake_r    <= 1'b0;
         busResetActive_r <= 1'b0;
         hostResumeSeen_r <= 1'b0;
         idleResuspend_r  <= 1'b0;
      end
      else
      begin
         state_r          <= state_nxt;
         rstFromWake_r    <= rstFromWake_nxt;
         busResetActive_r <= state_nxt == ST_IN_RESET;
         hostResumeSeen_r <= resumeHit;
         idleResuspend_r  <= resuspHit;
      end
   end

   assign busResetActive = busResetActive_r;
   assign hostResumeSeen = hostResumeSeen_r;
   assign idleResuspend  = idleResuspend_r;
   assign linkState      = state_r;

endmodule

// ===== hw/hbf_pkg.sv
// Shared constants, register map and types of the bus state filter block.
package hbf_pkg;

   // Clock rates: the filter values count periods of the 60 MHz PHY clock.
   localparam int unsigned SYS_CLK_HZ      = 20_000_000;
   localparam int unsigned PHY_CLK_HZ      = 60_000_000;
   localparam int unsigned TICKS_PER_CYCLE = PHY_CLK_HZ / SYS_CLK_HZ;

   // Widths.
   localparam int unsigned ADDR_W  = 12;
   localparam int unsigned DATA_W  = 32;
   localparam int unsigned IDX_W   = 10;
   localparam int unsigned QUAL_W  = 20;
   localparam int unsigned SHORT_W = 16;

   // Register indices; the byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_RESET_FILT_LOW  = 10'h214;
   localparam logic [IDX_W-1:0] IDX_RESET_FILT_HIGH = 10'h215;
   localparam logic [IDX_W-1:0] IDX_RESUME_LOW      = 10'h218;
   localparam logic [IDX_W-1:0] IDX_RESUME_HIGH     = 10'h219;
   localparam logic [IDX_W-1:0] IDX_IDLE_LOW        = 10'h21C;
   localparam logic [IDX_W-1:0] IDX_IDLE_MID        = 10'h21D;
   localparam logic [IDX_W-1:0] IDX_IDLE_TOP        = 10'h21E;
   localparam logic [IDX_W-1:0] IDX_STATUS          = 10'h220;

   // Reset values.
   localparam logic [7:0] RST_RESET_FILT_LOW  = 8'hB4;
   localparam logic [7:0] RST_RESET_FILT_HIGH = 8'h00;
   localparam logic [7:0] RST_RESUME_LOW      = 8'hB4;
   localparam logic [7:0] RST_RESUME_HIGH     = 8'h00;
   localparam logic [7:0] RST_IDLE_LOW        = 8'h60;
   localparam logic [7:0] RST_IDLE_MID        = 8'hEA;
   localparam logic [3:0] RST_IDLE_TOP        = 4'h0;

   // Field positions.
   localparam int unsigned IDLE_TOP_LSB   = 4;
   localparam int unsigned IDLE_TOP_W     = 4;
   localparam int unsigned STAT_STATE_LSB = 0;
   localparam int unsigned STAT_RESET_BIT = 3;
   localparam int unsigned STAT_LINE_LSB  = 4;

   // Filter controller states, Gray coded along the usual path.
   typedef enum logic [2:0]
   {
      ST_SLEEP    = 3'b000,
      ST_WAKE_CHK = 3'b001,
      ST_RES_QUAL = 3'b011,
      ST_AWAKE    = 3'b010,
      ST_RST_QUAL = 3'b110,
      ST_IN_RESET = 3'b111
   } hbf_state_t;

   // Line state as reported by the PHY receiver.
   typedef enum logic [1:0]
   {
      LS_IDLE   = 2'b00,
      LS_RESUME = 2'b01,
      LS_RESET  = 2'b10,
      LS_OTHER  = 2'b11
   } hbf_line_t;

   // Byte address of a register index.
   function automatic logic [ADDR_W-1:0] hbf_reg_addr(input logic [IDX_W-1:0] idx);
      return {idx, 2'b00};
   endfunction

endpackage

// ===== hw/hbf_qual_timer.sv
// Qualification timer counting elapsed PHY clock periods.
`timescale 1ns/10ps
module hbf_qual_timer
   import hbf_pkg::*;
#(
   parameter int unsigned TW    = QUAL_W,
   parameter int unsigned TICKS = TICKS_PER_CYCLE
)
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Timer control
   hbf_timer_if.timer tmr
);
   localparam logic [TW:0] STEP = (TW + 1)'(TICKS);

   logic [TW:0] elapsed_r;
   logic [TW:0] elapsed_nxt;
   wire         reached = elapsed_r >= {1'b0, tmr.limit};

   if (TICKS < 1 || TICKS >= (1 << TW))
   begin : g_bad_ticks
      $error("hbf_qual_timer: tick step out of range");
   end

   // Each system cycle stands for TICKS PHY periods; the count stops once reached.
   assign elapsed_nxt = !tmr.run ? '0 : (reached ? elapsed_r : elapsed_r + STEP);
   assign tmr.done    = tmr.run && reached;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         elapsed_r <= '0;
      else
         elapsed_r <= elapsed_nxt;
   end
endmodule

// ===== hw/hbf_sync2.sv
// Two flip-flop synchroniser for asynchronous level inputs.
`timescale 1ns/10ps
module hbf_sync2 #(parameter int unsigned W = 1)
(
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         resetn,
   // Data
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] stage1_r;
   logic [W-1:0] stage2_r;

   if (W < 1)
   begin : g_bad_width
      $error("hbf_sync2: width must be at least one");
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         stage1_r <= '0;
         stage2_r <= '0;
      end
      else
      begin
         stage1_r <= asyncIn;
         stage2_r <= stage1_r;
      end
   end

   assign syncOut = stage2_r;
endmodule

// ===== hw/hbf_timer_if.sv
// Interface between the filter controller and its qualification timer.
`timescale 1ns/10ps
interface hbf_timer_if #(parameter int unsigned QUAL_W = 20);
   logic              run;
   logic [QUAL_W-1:0] limit;
   logic              done;

   modport ctrl  (output run, output limit, input done);
   modport timer (input run, input limit, output done);
endinterface

// ===== testbench/hbf_bus_state_filters_properties.sv
// Concurrent checks on the ports of the bus state filter block.
`timescale 1ns/10ps
module hbf_bus_state_filters_properties
   import hbf_pkg::*;
(
   // Clock and reset
   input wire logic              sys_clk,
   input wire logic              resetn,
   // APB slave
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] prdata,
   // Qualified bus events
   input wire logic              busResetActive,
   input wire logic              hostResumeSeen,
   input wire logic              idleResuspend,
   input wire logic [2:0]        linkState
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////
   wire readAccess = psel && penable && !pwrite;

   sequence resumeDone;
      linkState == ST_RES_QUAL ##1 linkState == ST_AWAKE;
   endsequence

   sequence idleDone;
      linkState == ST_WAKE_CHK ##1 linkState == ST_SLEEP;
   endsequence
   ////////////////////////////////////////////////////////////
   rst_flag_state_a: assert property (busResetActive == (linkState == ST_IN_RESET))
      else $error("reset flag differs from state");
   rst_after_qual_a: assert property ($rose(busResetActive) |-> $past(linkState) == ST_RST_QUAL)
      else $error("bus reset without qualification");
   resume_single_a: assert property (hostResumeSeen |=> !hostResumeSeen)
      else $error("resume pulse too long");
   resume_after_qual_a: assert property (resumeDone |-> ##[0:1] hostResumeSeen)
      else $error("resume pulse missing");
   resume_cause_a: assert property (hostResumeSeen |->
      ($past(linkState) == ST_RES_QUAL || $past(linkState, 2) == ST_RES_QUAL))
      else $error("resume pulse without qualification");
   idle_single_a: assert property (idleResuspend |=> !idleResuspend)
      else $error("idle pulse too long");
   idle_after_wake_a: assert property (idleDone |-> ##[0:1] idleResuspend)
      else $error("idle pulse missing");
   idle_cause_a: assert property (idleResuspend |->
      ($past(linkState) == ST_WAKE_CHK || $past(linkState, 2) == ST_WAKE_CHK))
      else $error("idle pulse without wake check");
   read_upper_zero_a: assert property (readAccess |-> prdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   top_reserved_a: assert property (readAccess && paddr[11:2] == IDX_IDLE_TOP |-> prdata[3:0] == 4'h0)
      else $error("reserved idle bits set");
endmodule

bind hbf_bus_state_filters hbf_bus_state_filters_properties chk
(
   .sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .prdata,
   .busResetActive, .hostResumeSeen, .idleResuspend, .linkState
);

// ===== testbench/hbf_host_model.sv
// Behavioural host that drives the line state and the wake indication.
`timescale 1ns/10ps
module hbf_host_model
   import hbf_pkg::*;
(
   // Clock
   input  wire logic       sys_clk,
   // Line towards the device
   output logic      [1:0] lineState,
   output logic            wakeStable
);
   initial
   begin
      lineState = LS_IDLE;
      wakeStable = 1'h0;
   end

   task automatic drive(input hbf_line_t s);
      @(posedge sys_clk);
      lineState <= s;
   endtask

   task automatic wake(input logic w);
      @(posedge sys_clk);
      wakeStable <= w;
   endtask
endmodule

// ===== testbench/test_hbf_bus_state_filters.sv
// Self-checking testbench of the bus state filter block.
`timescale 1ns/10ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin errCount++; $display("Error %0t %h %h", $time, a, b); end end
module test_hbf_bus_state_filters
   import hbf_pkg::*;
;
   typedef struct {logic [9:0] idx; logic wr; logic stb; logic [7:0] wd; logic [7:0] ex; logic er;} hbf_row_t;
   hbf_row_t          rows [13] = '{'{10'h214, 1'h0, 1'h1, 8'h00, 8'hB4, 1'h0},
      '{10'h215, 1'h0, 1'h1, 8'h00, 8'h00, 1'h0}, '{10'h218, 1'h0, 1'h1, 8'h00, 8'hB4, 1'h0},
      '{10'h219, 1'h0, 1'h1, 8'h00, 8'h00, 1'h0}, '{10'h21C, 1'h0, 1'h1, 8'h00, 8'h60, 1'h0},
      '{10'h21D, 1'h0, 1'h1, 8'h00, 8'hEA, 1'h0}, '{10'h21E, 1'h0, 1'h1, 8'h00, 8'h00, 1'h0},
      '{10'h215, 1'h1, 1'h1, 8'hA5, 8'hA5, 1'h0}, '{10'h21E, 1'h1, 1'h1, 8'hFF, 8'hF0, 1'h0},
      '{10'h219, 1'h1, 1'h1, 8'h5A, 8'h5A, 1'h0}, '{10'h218, 1'h1, 1'h0, 8'h11, 8'hB4, 1'h0},
      '{10'h21C, 1'h1, 1'h1, 8'h3C, 8'h3C, 1'h0}, '{10'h216, 1'h1, 1'h1, 8'h77, 8'h00, 1'h1}};
   logic [15:0]       rv [4] = '{16'h0000, 16'h0006, 16'h0007, 16'h0100};
   logic              sys_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, rd;
   logic [3:0]        pstrb;
   wire  [1:0]        lineState;
   wire               wakeStable;
   logic              devResumeReq, suspendReq, busResetActive, hostResumeSeen, idleResuspend;
   logic              seenRes, seenRst;
   logic [2:0]        linkState;
   int                errCount = 0, nTests = 0, cyc = 0, n;

   hbf_bus_state_filters uut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .lineState, .wakeStable, .devResumeReq, .suspendReq,
      .busResetActive, .hostResumeSeen, .idleResuspend, .linkState);
   hbf_host_model host (.sys_clk, .lineState, .wakeStable);
   ////////////////////////////////////////////////////////////
   initial
   begin
      sys_clk = 1'h0;
      forever #25 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         errCount++;
         final_report();
      end
   end

   always @(negedge sys_clk)
   begin
      if (hostResumeSeen === 1'h1) seenRes <= 1'h1;
      if (busResetActive === 1'h1) seenRst <= 1'h1;
   end
   ////////////////////////////////////////////////////////////
   task automatic final_report();
      if (errCount == 0 && nTests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // A write or read cycle; the byte address is four times the index.
   task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d, input logic s);
      @(posedge sys_clk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h5A_5A5A, d};
      pstrb <= {3'h7, s};
      @(posedge sys_clk);
      penable <= 1'h1;
      do @(posedge sys_clk); while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic waitState(input logic [2:0] s, input int lim);
      int t;
      t = 0;
      while (linkState !== s && t < lim)
      begin
         @(negedge sys_clk);
         t++;
      end
      if (linkState !== s)
         errCount++;
   endtask

   task automatic dwell(input logic [2:0] s, output int c);
      waitState(s, 100);
      c = 0;
      while (linkState === s && c < 30000)
      begin
         @(negedge sys_clk);
         c++;
      end
   endtask

   task automatic goSleep();
      @(posedge sys_clk);
      suspendReq <= 1'h1;
      @(posedge sys_clk);
      suspendReq <= 1'h0;
      waitState(ST_SLEEP, 20);
   endtask

   // Cycles spent qualifying: whole clocks needed to reach the count, plus the start cycle.
   function automatic int expDwell(input int v);
      return (v + TICKS_PER_CYCLE - 1) / TICKS_PER_CYCLE + 1;
   endfunction
   ////////////////////////////////////////////////////////////
   initial
   begin
      {resetn, psel, penable, pwrite, paddr, pwdata, pstrb, devResumeReq, suspendReq} = '0;
      {seenRes, seenRst} = 2'h0;
      repeat (20) @(posedge sys_clk);
      resetn <= 1'h1;
      foreach (rows[i])
      begin
         if (rows[i].wr) apb(1'h1, rows[i].idx, rows[i].wd, rows[i].stb);
         apb(1'h0, rows[i].idx, 8'h00, 1'h1);
         `CHK(rd, {24'h00_0000, rows[i].ex})
         `CHK(er, rows[i].er)
      end
      foreach (rv[i])
      begin
         apb(1'h1, IDX_RESET_FILT_LOW, rv[i][7:0], 1'h1);
         apb(1'h1, IDX_RESET_FILT_HIGH, rv[i][15:8], 1'h1);
         host.drive(LS_RESET);
         dwell(ST_RST_QUAL, n);
         `CHK(n, expDwell(rv[i]))
         `CHK(busResetActive, 1'h1)
         host.drive(LS_IDLE);
         waitState(ST_AWAKE, 20);
      end
      // A reset state that breaks off early must not qualify.
      seenRst = 1'h0;
      host.drive(LS_RESET);
      repeat (10) @(posedge sys_clk);
      host.drive(LS_IDLE);
      waitState(ST_AWAKE, 20);
      `CHK(seenRst, 1'h0)
      `CHK(linkState, ST_AWAKE)
      apb(1'h1, IDX_RESUME_LOW, 8'h0A, 1'h1);
      goSleep();
      host.drive(LS_RESUME);
      seenRes = 1'h0;
      host.wake(1'h1);
      dwell(ST_RES_QUAL, n);
      `CHK(n, expDwell(16'h5A0A))
      repeat (3) @(negedge sys_clk);
      `CHK(seenRes, 1'h1)
      `CHK(linkState, ST_AWAKE)
      host.wake(1'h0);
      host.drive(LS_IDLE);
      apb(1'h1, IDX_IDLE_TOP, 8'h10, 1'h1);
      apb(1'h1, IDX_IDLE_MID, 8'h00, 1'h1);
      apb(1'h1, IDX_IDLE_LOW, 8'h09, 1'h1);
      goSleep();
      host.wake(1'h1);
      dwell(ST_WAKE_CHK, n);
      `CHK(n, expDwell(20'h1_0009))
      `CHK(linkState, ST_SLEEP)
      `CHK(idleResuspend, 1'h1)
      host.wake(1'h0);
      seenRes = 1'h0;
      @(posedge sys_clk);
      devResumeReq <= 1'h1;
      @(posedge sys_clk);
      devResumeReq <= 1'h0;
      waitState(ST_AWAKE, 20);
      repeat (3) @(negedge sys_clk);
      `CHK(linkState, ST_AWAKE)
      `CHK(seenRes, 1'h0)
      @(posedge sys_clk);
      resetn <= 1'h0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'h1;
      apb(1'h0, IDX_RESET_FILT_LOW, 8'h00, 1'h1);
      `CHK(rd, 32'h0000_00B4)
      final_report();
   end
endmodule
